//--- hdl/dsa_pkg.sv
// Package: data space access constants and carrier types
package dsa_pkg;
    localparam int EA_W = 16;                    // Byte effective address width
    localparam int PAGE_W = 8;                   // Page register width
    localparam int XADDR_W = EA_W + PAGE_W;      // Extended space, 16 Mbytes
    localparam int DATA_W = 16;                  // Word width
    localparam int BYTE_W = 8;                   // Lane width
    localparam int NEAR_W = 13;                  // Near absolute field width
    localparam logic [EA_W-1:0] SFR_LAST = 16'h0FFF;    // End of SFR region
    localparam logic [EA_W-1:0] RAM_FIRST = 16'h1000;   // First RAM byte
    localparam logic [EA_W-1:0] RAM_LAST = 16'hCFFF;    // End of 48 Kbyte RAM
    localparam logic [PAGE_W-1:0] PAGE_BASE = 8'h01;    // Page naming base space
    localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h01;   // Page register reset value
    localparam logic [EA_W-1:0] STEP_BYTE = 16'h0001;   // Byte post-increment
    localparam logic [EA_W-1:0] STEP_WORD = 16'h0002;   // Word post-increment
    localparam int RAM_WORDS = 24576;            // 48 Kbytes as words
    localparam int RAM_AW = 15;                  // RAM word address width

    // Addressing mode of a request
    typedef enum logic [1:0] {MODE_DIRECT, MODE_NEAR, MODE_INDIRECT, MODE_POSTINC} addr_mode_t;
    // Extension applied to a byte loaded into a working register
    typedef enum logic [1:0] {EXT_NONE, EXT_SIGN, EXT_ZERO} ext_op_t;

    // Request from one address generator
    typedef struct packed {
        logic valid;
        logic word;
        addr_mode_t mode;
        logic [EA_W-1:0] operand;   // Absolute field or pointer value
        logic page_space;           // Use page register for extended space
    } agu_req_t;
endpackage

//--- hdl/dsa_ram.sv
// Byte-lane data RAM with registered read data
`timescale 1ns/1ns
module dsa_ram #(
    parameter int WORDS = 24576,
    parameter int AW = 15
) (
    input wire logic clk_i,                  // Core clock
    input wire logic [AW-1:0] raddr_i,       // Shared read word address
    output logic [15:0] rdata_o,             // Registered read word
    input wire logic [AW-1:0] waddr_i,       // Shared write word address
    input wire logic [1:0] we_i,             // Per-lane write enables
    input wire logic [15:0] wdata_i          // Write word
);
    logic [15:0] mem [WORDS];

    // One word decode, separate lane write lines
    always_ff @(posedge clk_i)
    begin
        if (we_i[0])
        begin
            mem[waddr_i][7:0] <= wdata_i[7:0];
        end
        if (we_i[1])
        begin
            mem[waddr_i][15:8] <= wdata_i[15:8];
        end
        rdata_o <= mem[raddr_i];
    end
endmodule // dsa_ram

//--- hdl/data_space_access_unit.sv
// Data space access unit: address generation, byte lanes, alignment trap
// Behaviour
// - Effective addresses are 16-bit byte addresses over a 64 Kbyte base space.
// - Read and write paths each compute their own address.
// - Read or write page register extends the address to 16 Mbytes.
// - Only SFR plus 48 Kbyte RAM implemented; elsewhere reads return zero.
// - Words of 16 bits; low byte even address, high byte odd.
// - Post-increment adds one for bytes, two for words.
// - Byte read fetches whole word, picks byte by bit zero, low lane.
// - Shared word decode, per-lane write enables; byte write touches one lane.
// - Word access at odd address raises address error trap.
// - Misaligned read still completes; its data is valid the cycle after the trap.
// - Misaligned write executes but memory write is suppressed.
// - Byte load into working register without extension writes only its low byte.
// - Sign extend widens 8-bit to 16-bit; zero extend clears high byte.
// - Addresses 0x0000 to 0x0FFF decode to special function registers.
// - Unused SFR addresses read as zero when no write is valid in the same cycle.
// - Lowest 8 Kbytes reachable through 13-bit absolute field.
`timescale 1ns/1ns
module data_space_access_unit #(
    parameter int RAM_WORDS = dsa_pkg::RAM_WORDS
) (
    input wire logic CLOCK_I,                        // Core clock, 25 MHz
    input wire logic RST_N_I,                        // Async reset, active low
    input wire dsa_pkg::agu_req_t RD_REQ_I,          // Read generator request
    input wire logic RD_BYTE_I,                      // Read is a byte access
    input wire dsa_pkg::agu_req_t WR_REQ_I,          // Write generator request
    input wire logic [15:0] WR_DATA_I,               // Write data, byte on low lane
    input wire logic PAGE_WE_I,                      // Load page registers
    input wire logic [7:0] RD_PAGE_I,                // New read page
    input wire logic [7:0] WR_PAGE_I,                // New write page
    input wire logic [15:0] SFR_RDATA_I,             // SFR read word
    input wire logic SFR_HIT_I,                      // SFR address implemented
    input wire logic [15:0] WREG_I,                  // Current working register
    input wire dsa_pkg::ext_op_t EXT_OP_I,           // Extension for byte loads
    output logic [15:0] RD_DATA_O,                   // Read data, two cycles later
    output logic RD_VALID_O,                         // Read data valid
    output logic [15:0] WREG_O,                      // Working register result
    output logic [15:0] RD_PTR_O,                    // Updated read pointer
    output logic [15:0] WR_PTR_O,                    // Updated write pointer
    output logic [23:0] RD_XADDR_O,                  // Extended read address
    output logic [23:0] WR_XADDR_O,                  // Extended write address
    output logic [15:0] SFR_ADDR_O,                  // SFR access address
    output logic [1:0] SFR_WE_O,                     // SFR lane write enables
    output logic [15:0] SFR_WDATA_O,                 // SFR write word
    output logic ADDR_ERR_O,                         // Address error trap request
    output logic [7:0] RD_PAGE_O,                    // Read page register
    output logic [7:0] WR_PAGE_O                     // Write page register
);
    // ************************************************************
    // Page registers
    // ************************************************************
    logic [7:0] read_page_register_q;
    logic [7:0] write_page_register_q;

    // Software-loaded page registers
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            read_page_register_q <= dsa_pkg::PAGE_RESET;
            write_page_register_q <= dsa_pkg::PAGE_RESET;
        end
        else if (PAGE_WE_I)
        begin
            read_page_register_q <= RD_PAGE_I;
            write_page_register_q <= WR_PAGE_I;
        end
    end

    // ************************************************************
    // Address generation, one function used by both paths
    // ************************************************************
    function automatic logic [15:0] agu_ea(input dsa_pkg::agu_req_t r);
        logic [15:0] ea;
        ea = r.operand;
        if (r.mode == dsa_pkg::MODE_NEAR)
        begin
            ea = {3'h0, r.operand[dsa_pkg::NEAR_W-1:0]};
        end
        return ea;
    endfunction

    function automatic logic [15:0] agu_next(input dsa_pkg::agu_req_t r, input logic byte_op);
        logic [15:0] nx;
        nx = r.operand;
        if (r.mode == dsa_pkg::MODE_POSTINC)
        begin
            nx = r.operand + (byte_op ? dsa_pkg::STEP_BYTE : dsa_pkg::STEP_WORD);
        end
        return nx;
    endfunction

    logic [15:0] rd_ea;
    logic [15:0] wr_ea;
    logic rd_mis;
    logic wr_mis;
    logic wr_byte;
    logic rd_byte;
    // Separate read and write effective addresses
    assign rd_ea = agu_ea(RD_REQ_I);
    assign wr_ea = agu_ea(WR_REQ_I);
    assign wr_byte = !WR_REQ_I.word;
    assign rd_byte = RD_BYTE_I || !RD_REQ_I.word;
    // Odd word access detection; a forced byte read is never misaligned
    assign rd_mis = RD_REQ_I.valid && !rd_byte && rd_ea[0];
    assign wr_mis = WR_REQ_I.valid && WR_REQ_I.word && wr_ea[0];

    // Region decode
    logic rd_sfr;
    logic rd_ram;
    logic wr_sfr;
    logic wr_ram;
    logic rd_base;
    logic wr_base;
    assign rd_base = !RD_REQ_I.page_space || read_page_register_q == dsa_pkg::PAGE_BASE;
    assign wr_base = !WR_REQ_I.page_space || write_page_register_q == dsa_pkg::PAGE_BASE;
    assign rd_sfr = rd_base && rd_ea <= dsa_pkg::SFR_LAST;
    assign rd_ram = rd_base && rd_ea >= dsa_pkg::RAM_FIRST && rd_ea <= dsa_pkg::RAM_LAST;
    assign wr_sfr = wr_base && wr_ea <= dsa_pkg::SFR_LAST;
    assign wr_ram = wr_base && wr_ea >= dsa_pkg::RAM_FIRST && wr_ea <= dsa_pkg::RAM_LAST;

    // Lane enables: one lane for a byte, both for a word, none if misaligned
    logic [1:0] lane_we;
    always_comb
    begin
        lane_we = 2'h0;
        if (WR_REQ_I.valid && !wr_mis)
        begin
            lane_we = wr_byte ? (wr_ea[0] ? 2'h2 : 2'h1) : 2'h3;
        end
    end
    logic [15:0] lane_wdata;
    assign lane_wdata = wr_byte ? {WR_DATA_I[7:0], WR_DATA_I[7:0]} : WR_DATA_I;

    // ************************************************************
    // Data RAM
    // ************************************************************
    logic [14:0] ram_raddr;
    logic [14:0] ram_waddr;
    logic [15:0] ram_rdata;
    logic [15:0] rd_off;
    logic [15:0] wr_off;
    assign rd_off = rd_ea - dsa_pkg::RAM_FIRST;
    assign wr_off = wr_ea - dsa_pkg::RAM_FIRST;
    assign ram_raddr = rd_off[15:1];
    assign ram_waddr = wr_off[15:1];

    dsa_ram #(.WORDS(RAM_WORDS), .AW(dsa_pkg::RAM_AW)) u_ram (
        .clk_i(CLOCK_I),
        .raddr_i(ram_raddr),
        .rdata_o(ram_rdata),
        .waddr_i(ram_waddr),
        .we_i(wr_ram ? lane_we : 2'h0),
        .wdata_i(lane_wdata)
    );

    // ************************************************************
    // Read return stage
    // ************************************************************
    logic rd_v_q;
    logic rd_byte_q;
    logic rd_hi_q;
    logic rd_sfr_q;
    logic rd_ram_q;
    // Registered read context
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rd_v_q <= 1'b0;
            rd_byte_q <= 1'b0;
            rd_hi_q <= 1'b0;
            rd_sfr_q <= 1'b0;
            rd_ram_q <= 1'b0;
        end
        else
        begin
            rd_v_q <= RD_REQ_I.valid;
            rd_byte_q <= rd_byte;
            rd_hi_q <= rd_ea[0];
            rd_sfr_q <= rd_sfr;
            rd_ram_q <= rd_ram;
        end
    end

    logic [15:0] word_sel;
    logic [15:0] data_d;
    // Region select, zero for unimplemented, byte lane to low byte
    // SFR answer follows the registered SFR address, so it is taken a cycle
    // after the request, beside the RAM word; back-to-back reads stay right
    always_comb
    begin
        word_sel = 16'h0000;
        if (rd_ram_q)
        begin
            word_sel = ram_rdata;
        end
        else if (rd_sfr_q && SFR_HIT_I)
        begin
            word_sel = SFR_RDATA_I;
        end
        data_d = word_sel;
        if (rd_byte_q)
        begin
            data_d = {8'h00, rd_hi_q ? word_sel[15:8] : word_sel[7:0]};
        end
    end

    logic [15:0] wreg_d;
    // Byte load with optional extension
    always_comb
    begin
        unique case (EXT_OP_I)
            dsa_pkg::EXT_SIGN: wreg_d = {{8{data_d[7]}}, data_d[7:0]};
            dsa_pkg::EXT_ZERO: wreg_d = {8'h00, data_d[7:0]};
            default: wreg_d = {WREG_I[15:8], data_d[7:0]};
        endcase
        if (!rd_byte_q)
        begin
            wreg_d = data_d;
        end
    end

    // Registered read results
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            RD_DATA_O <= 16'h0000;
            RD_VALID_O <= 1'b0;
            WREG_O <= 16'h0000;
        end
        else
        begin
            RD_DATA_O <= data_d;
            RD_VALID_O <= rd_v_q;
            WREG_O <= rd_v_q ? wreg_d : WREG_I;
        end
    end

    // ************************************************************
    // Address, SFR strobe and trap outputs
    // ************************************************************
    // Registered addresses, pointers and SFR strobes
    always_ff @(posedge CLOCK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            RD_PTR_O <= 16'h0000;
            WR_PTR_O <= 16'h0000;
            RD_XADDR_O <= 24'h000000;
            WR_XADDR_O <= 24'h000000;
            SFR_ADDR_O <= 16'h0000;
            SFR_WE_O <= 2'h0;
            SFR_WDATA_O <= 16'h0000;
            ADDR_ERR_O <= 1'b0;
        end
        else
        begin
            RD_PTR_O <= agu_next(RD_REQ_I, rd_byte);
            WR_PTR_O <= agu_next(WR_REQ_I, wr_byte);
            RD_XADDR_O <= {read_page_register_q, rd_ea};
            WR_XADDR_O <= {write_page_register_q, wr_ea};
            SFR_ADDR_O <= WR_REQ_I.valid ? wr_ea : rd_ea;
            SFR_WE_O <= wr_sfr ? lane_we : 2'h0;
            SFR_WDATA_O <= lane_wdata;
            ADDR_ERR_O <= rd_mis || wr_mis;
        end
    end

    assign RD_PAGE_O = read_page_register_q;
    assign WR_PAGE_O = write_page_register_q;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_ODD_TRAP: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (WR_REQ_I.valid && WR_REQ_I.word && wr_ea[0]) |=> ADDR_ERR_O)
        else $error("odd word write without trap");
    AST_NO_FALSE_TRAP: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        !(rd_mis || wr_mis) |=> !ADDR_ERR_O)
        else $error("trap without misaligned access");
    AST_SUPPRESS: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        wr_mis |=> SFR_WE_O == 2'h0)
        else $error("misaligned write reached SFR");
    AST_BYTE_LANE: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (WR_REQ_I.valid && wr_byte && wr_sfr) |=> $onehot(SFR_WE_O))
        else $error("byte write hit two lanes");
    AST_READ_DONE: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        rd_mis |-> ##2 RD_VALID_O)
        else $error("misaligned read not completed");
    AST_POSTINC: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (RD_REQ_I.mode == dsa_pkg::MODE_POSTINC && !RD_REQ_I.word) |=>
        RD_PTR_O == $past(RD_REQ_I.operand) + 16'h0001)
        else $error("byte post-increment wrong");
    AST_BYTE_HIGH_ZERO: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (RD_REQ_I.valid && !RD_REQ_I.word) |-> ##2 RD_DATA_O[15:8] == 8'h00)
        else $error("byte read upper lane not zero");
    AST_UNMAPPED_ZERO: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (RD_REQ_I.valid && !rd_sfr && !rd_ram) |-> ##2 RD_DATA_O == 16'h0000)
        else $error("unimplemented read not zero");
    AST_XADDR: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        1'b1 |=> WR_XADDR_O[23:16] == $past(write_page_register_q))
        else $error("write page not applied");
    COV_TRAP: cover property (@(posedge CLOCK_I) ADDR_ERR_O);
    COV_BYTE_HI: cover property (@(posedge CLOCK_I) rd_v_q && rd_byte_q && rd_hi_q);
    COV_SFR_WR: cover property (@(posedge CLOCK_I) SFR_WE_O == 2'h3);
endmodule // data_space_access_unit

//--- test/sfr_model.sv
// Partner model of the special function register space seen by the unit
`timescale 1ns/1ns
module sfr_model (
    input wire logic clk_i,              // Core clock
    input wire logic [15:0] addr_i,      // SFR access address
    input wire logic [1:0] we_i,         // Lane write enables
    input wire logic [15:0] wdata_i,     // Write word
    output logic [15:0] rdata_o,         // Read word
    output logic hit_o                   // Address implemented
);
    logic [15:0] mem_q [0:1023];
    logic [15:0] junk_q = 16'h5A3C;

    // ****************************************
    // Decode and read
    // ****************************************
    // Lower half of the region implemented, upper half left unused
    assign hit_o = (addr_i < 16'h0800);
    // Unused places show a churning pattern, never a stale word
    assign rdata_o = hit_o ? mem_q[addr_i[10:1]] : junk_q;

    // Lane writes, each byte on its own strobe; low byte at the even address
    always @(posedge clk_i)
    begin
        junk_q <= ~{junk_q[14:0], junk_q[15]};
        if (we_i[0] && hit_o)
            mem_q[addr_i[10:1]][7:0] <= wdata_i[7:0];
        if (we_i[1] && hit_o)
            mem_q[addr_i[10:1]][15:8] <= wdata_i[15:8];
    end
endmodule // sfr_model

//--- test/tb.sv
// Self-checking bench for the data space access unit
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module tb;
    typedef struct packed {
        logic wr;
        logic word;
        dsa_pkg::addr_mode_t mode;
        logic [15:0] ea;
        logic [15:0] val;
    } row_t;
    localparam dsa_pkg::addr_mode_t DR = dsa_pkg::MODE_DIRECT;
    localparam dsa_pkg::addr_mode_t NR = dsa_pkg::MODE_NEAR;
    localparam dsa_pkg::addr_mode_t IN = dsa_pkg::MODE_INDIRECT;
    localparam dsa_pkg::addr_mode_t PI = dsa_pkg::MODE_POSTINC;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    dsa_pkg::agu_req_t rd_req = '0;
    dsa_pkg::agu_req_t wr_req = '0;
    logic rd_byte = 1'b0;
    logic force_byte = 1'b0;
    logic [15:0] wr_data = 16'h0000;
    logic page_we = 1'b0;
    logic [7:0] rd_page = 8'h01;
    logic [7:0] wr_page = 8'h01;
    logic [15:0] wreg = 16'h1234;
    dsa_pkg::ext_op_t ext_op = dsa_pkg::EXT_NONE;
    logic [15:0] sfr_rdata, rd_data, wreg_o, rd_ptr, wr_ptr, sfr_addr, sfr_wdata;
    logic [23:0] rd_xa, wr_xa, last_xa;
    logic [7:0] rd_page_o, wr_page_o;
    logic [1:0] sfr_we;
    logic sfr_hit, rd_valid, addr_err, last_err, last_valid;
    logic [15:0] last_data, last_ptr, last_wreg, ea;
    row_t r;
    row_t rows [0:20];
    dsa_pkg::ext_op_t ext_ops [0:3] = '{dsa_pkg::EXT_NONE, dsa_pkg::EXT_SIGN,
                                        dsa_pkg::EXT_ZERO, dsa_pkg::EXT_SIGN};
    logic [15:0] ext_ea [0:3] = '{16'h1001, 16'h1001, 16'h1001, 16'h1000};
    logic [15:0] ext_exp [0:3] = '{16'h12A5, 16'hFFA5, 16'h00A5, 16'h005A};
    int bad_count = 0;
    int total_checks = 0;

    // ****************************************
    // Design and partner
    // ****************************************
    data_space_access_unit i_dut (
        .CLOCK_I(clk), .RST_N_I(rst_n), .RD_REQ_I(rd_req), .RD_BYTE_I(rd_byte),
        .WR_REQ_I(wr_req), .WR_DATA_I(wr_data), .PAGE_WE_I(page_we),
        .RD_PAGE_I(rd_page), .WR_PAGE_I(wr_page), .SFR_RDATA_I(sfr_rdata),
        .SFR_HIT_I(sfr_hit), .WREG_I(wreg), .EXT_OP_I(ext_op), .RD_DATA_O(rd_data),
        .RD_VALID_O(rd_valid), .WREG_O(wreg_o), .RD_PTR_O(rd_ptr), .WR_PTR_O(wr_ptr),
        .RD_XADDR_O(rd_xa), .WR_XADDR_O(wr_xa), .SFR_ADDR_O(sfr_addr),
        .SFR_WE_O(sfr_we), .SFR_WDATA_O(sfr_wdata), .ADDR_ERR_O(addr_err),
        .RD_PAGE_O(rd_page_o), .WR_PAGE_O(wr_page_o));
    sfr_model i_sfr (.clk_i(clk), .addr_i(sfr_addr), .we_i(sfr_we), .wdata_i(sfr_wdata),
        .rdata_o(sfr_rdata), .hit_o(sfr_hit));

    // Core clock, 40 ns period
    always #20 clk = ~clk;

    // Advance n edges, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One write request, capturing the one-cycle answers
    task automatic wr(input logic w, input dsa_pkg::addr_mode_t m, input logic [15:0] a,
                      input logic [15:0] d, input logic ps);
        wr_req = '{1'b1, w, m, a, ps};
        wr_data = d;
        tick(1);
        last_err = addr_err;
        last_ptr = wr_ptr;
        last_xa = wr_xa;
        wr_req = '0;
        tick(1);
    endtask

    // One read request; trap and pointer after one edge, data after two
    task automatic rd(input logic w, input dsa_pkg::addr_mode_t m, input logic [15:0] a,
                      input logic ps);
        rd_req = '{1'b1, w, m, a, ps};
        rd_byte = ~w | force_byte;
        tick(1);
        last_err = addr_err;
        last_ptr = rd_ptr;
        last_xa = rd_xa;
        rd_req = '0;
        tick(1);
        last_data = rd_data;
        last_valid = rd_valid;
        last_wreg = wreg_o;
    endtask

    task automatic done(input string name);
        $display("test %s finished, checks %0d", name, total_checks);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        rows = '{'{1'b1, 1'b1, DR, 16'h1000, 16'hA55A}, '{1'b0, 1'b1, DR, 16'h1000, 16'hA55A},
            '{1'b0, 1'b0, DR, 16'h1000, 16'h005A}, '{1'b0, 1'b0, IN, 16'h1001, 16'h00A5},
            '{1'b1, 1'b1, DR, 16'h1002, 16'h1234}, '{1'b1, 1'b0, PI, 16'h1003, 16'h0077},
            '{1'b1, 1'b1, DR, 16'h1003, 16'hFFFF}, '{1'b0, 1'b1, PI, 16'h1002, 16'h7734},
            '{1'b0, 1'b0, PI, 16'h1003, 16'h0077}, '{1'b1, 1'b1, PI, 16'hCFFE, 16'h0F0F},
            '{1'b0, 1'b1, DR, 16'hCFFE, 16'h0F0F}, '{1'b1, 1'b1, DR, 16'hD000, 16'hFFFF},
            '{1'b0, 1'b1, DR, 16'hD000, 16'h0000}, '{1'b0, 1'b0, DR, 16'hFFFF, 16'h0000},
            '{1'b0, 1'b1, NR, 16'hF000, 16'hA55A}, '{1'b1, 1'b1, NR, 16'hE100, 16'hBEEF},
            '{1'b0, 1'b1, DR, 16'h0100, 16'hBEEF}, '{1'b1, 1'b0, DR, 16'h0101, 16'h0011},
            '{1'b0, 1'b1, DR, 16'h0100, 16'h11EF}, '{1'b0, 1'b1, DR, 16'h0F00, 16'h0000},
            '{1'b0, 1'b0, DR, 16'h0F01, 16'h0000}};
        tick(5);
        `CHK(rd_page_o, 8'h01)
        `CHK(wr_page_o, 8'h01)
        `CHK(addr_err, 1'b0)
        rst_n = 1'b1;
        tick(1);
        done("reset");
        // Table of plain accesses, answers worked out per row
        foreach (rows[i])
        begin
            r = rows[i];
            ea = (r.mode == NR) ? {3'h0, r.ea[12:0]} : r.ea;
            if (r.wr)
                wr(r.word, r.mode, r.ea, r.val, 1'b0);
            else
                rd(r.word, r.mode, r.ea, 1'b0);
            `CHK(last_err, r.word & r.ea[0])
            `CHK(last_xa, {8'h01, ea})
            if (r.mode == PI)
                `CHK(last_ptr, r.ea + (r.word ? 16'h0002 : 16'h0001))
            if (!r.wr)
            begin
                `CHK(last_data, r.val)
                `CHK(last_valid, 1'b1)
            end
        end
        done("table");
        // Odd word read completes; the trap lasts one cycle only
        rd(1'b1, DR, 16'h1001, 1'b0);
        `CHK(last_err, 1'b1)
        `CHK(last_valid, 1'b1)
        `CHK(addr_err, 1'b0)
        wr(1'b1, IN, 16'h1005, 16'hFFFF, 1'b0);
        `CHK(last_err, 1'b1)
        `CHK(addr_err, 1'b0)
        // A forced byte read at an odd address is not a word access
        force_byte = 1'b1;
        rd(1'b1, DR, 16'h1001, 1'b0);
        force_byte = 1'b0;
        `CHK(last_err, 1'b0)
        `CHK(last_data, 16'h00A5)
        done("misaligned");
        // Byte loads into the working register with each extension
        for (int k = 0; k < 4; k++)
        begin
            ext_op = ext_ops[k];
            rd(1'b0, DR, ext_ea[k], 1'b0);
            `CHK(last_wreg, ext_exp[k])
        end
        ext_op = dsa_pkg::EXT_NONE;
        done("extend");
        // Read and write generators working in the same cycle
        rd_req = '{1'b1, 1'b1, PI, 16'h1000, 1'b0};
        rd_byte = 1'b0;
        wr_req = '{1'b1, 1'b1, PI, 16'h1006, 1'b0};
        wr_data = 16'h4321;
        tick(1);
        `CHK(rd_ptr, 16'h1002)
        `CHK(wr_ptr, 16'h1008)
        rd_req = '0;
        wr_req = '0;
        tick(1);
        `CHK(rd_data, 16'hA55A)
        `CHK(rd_valid, 1'b1)
        rd(1'b1, DR, 16'h1006, 1'b0);
        `CHK(last_data, 16'h4321)
        done("parallel");
        // Pages other than the base one reach the extended space only
        page_we = 1'b1;
        rd_page = 8'h02;
        wr_page = 8'h03;
        tick(1);
        page_we = 1'b0;
        `CHK(rd_page_o, 8'h02)
        `CHK(wr_page_o, 8'h03)
        wr(1'b1, DR, 16'h1000, 16'h0BAD, 1'b1);
        `CHK(last_xa, 24'h031000)
        rd(1'b1, DR, 16'h1000, 1'b1);
        `CHK(last_xa, 24'h021000)
        `CHK(last_data, 16'h0000)
        rd(1'b1, DR, 16'h1000, 1'b0);
        `CHK(last_data, 16'hA55A)
        done("pages");
        // Mid-run reset brings the page registers home
        rst_n = 1'b0;
        tick(1);
        `CHK(rd_page_o, 8'h01)
        `CHK(wr_page_o, 8'h01)
        `CHK(rd_valid, 1'b0)
        `CHK(addr_err, 1'b0)
        rst_n = 1'b1;
        tick(1);
        rd(1'b1, DR, 16'h1000, 1'b1);
        `CHK(last_xa, 24'h011000)
        `CHK(last_data, 16'hA55A)
        done("reset again");
        results();
    end

    // Watchdog against a hung run
    initial
    begin
        #400000;
        bad_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        results();
    end
endmodule // tb
